// ==== verilog/msli_monitor_top.sv ====
// measurement sequencer, register file, limit flags and interrupt pin
`timescale 1ns/10ps
`default_nettype none
`include "msli_defines.svh"
module msli_monitor_top
  import msli_pkg::*;
#(
  parameter int CONV_TIMEOUT_CYC = `MSLI_CONV_TIMEOUT_CYC
)
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // register access from the serial front end
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       bus_active,
  // shared converter
  output logic            adc_start,
  output logic            adc_reset,
  output logic [2:0]      adc_chan,
  output logic            adc_ref_ext,
  input  wire logic       adc_done,
  input  wire logic [9:0] adc_data,
  // interrupt pin
  output logic            irq_out
);
  localparam logic [16:0] TIMEOUT_LAST = 17'(CONV_TIMEOUT_CYC - 1);

  msli_state_t state_q;
  msli_chan_t  cur_ch_q;
  logic [16:0] timer_q;
  logic        bus_active_q;
  logic [9:0]  sample_q;
  logic [7:0]  cfg1_q;
  logic [7:0]  ctl2_q;
  logic [7:0]  ctl3_q;
  logic [7:0]  mask1_q;
  logic [7:0]  mask2_q;
  logic [5:0]  stat1_q;
  logic        stat2_q;
  logic [9:0]  val_q    [0:6];
  logic [7:0]  lim_hi_q [0:6];
  logic [7:0]  lim_lo_q [0:6];
  logic [7:0]  rdata_d;
  logic [7:0]  lim_off;
  logic [7:0]  val_off;
  logic        abort;
  logic        ch_temp;
  logic        avg_vld;
  logic [9:0]  avg_res;
  logic [9:0]  store_val;
  logic        store_fire;
  logic        above;
  logic        below;
  logic        out_lim;
  logic [5:0]  set1;
  logic        set2;
  logic        rd_stat1;
  logic        rd_stat2;
  logic        any_irq;
  msli_chan_t  next_ch;

  // ***************************************************
  // sequencing
  // ***************************************************
  assign abort    = bus_active || !cfg1_q[`MSLI_CFG1_EN];
  assign ch_temp  = chan_is_temp(cur_ch_q);
  assign next_ch  = ctl2_q[`MSLI_CTL2_SINGLE] ? single_chan(ctl2_q[2:0])
                  : rr_next(cur_ch_q, cfg1_q[`MSLI_CFG1_PINS_AIN]);
  assign store_val  = ch_temp ? avg_res : sample_q;
  assign store_fire = (state_q == MSLI_ST_STORE) && !abort && (!ch_temp || avg_vld);

  msli_averager u_avg (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .clear        (abort),
    .avg_on       (!ctl2_q[`MSLI_CTL2_AVG_OFF]),
    .sample_valid ((state_q == MSLI_ST_WAIT) && adc_done && ch_temp && !abort),
    .sample       (adc_data),
    .result_valid (avg_vld),
    .result       (avg_res)
  );

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q  <= MSLI_ST_IDLE;
      cur_ch_q <= MSLI_CH_SUPPLY;
    end
    else if (abort)
    begin
      state_q <= MSLI_ST_IDLE;
    end
    else
    begin
      case (state_q)
        MSLI_ST_IDLE:
        begin
          // restart right after the transaction
          state_q <= MSLI_ST_START;
          if (ctl2_q[`MSLI_CTL2_SINGLE])
          begin
            cur_ch_q <= single_chan(ctl2_q[2:0]);
          end
        end
        MSLI_ST_START:
        begin
          state_q <= MSLI_ST_WAIT;
        end
        MSLI_ST_WAIT:
        begin
          if (adc_done)
          begin
            state_q <= MSLI_ST_STORE;
          end
          else if (timer_q == TIMEOUT_LAST)
          begin
            state_q <= MSLI_ST_START;
          end
        end
        MSLI_ST_STORE:
        begin
          // back to back conversions, same channel while averaging
          state_q <= MSLI_ST_START;
          if (store_fire)
          begin
            cur_ch_q <= next_ch;
          end
        end
        default:
        begin
          state_q <= MSLI_ST_IDLE;
        end
      endcase
    end
  end

  // conversion watchdog, twice the slow external time
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      timer_q <= 17'h00000;
    end
    else if (state_q == MSLI_ST_WAIT)
    begin
      timer_q <= timer_q + 17'h00001;
    end
    else
    begin
      timer_q <= 17'h00000;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      adc_start    <= 1'b0;
      adc_reset    <= 1'b0;
      adc_chan     <= 3'h0;
      adc_ref_ext  <= 1'b0;
      bus_active_q <= 1'b0;
      sample_q     <= 10'h000;
    end
    else
    begin
      bus_active_q <= bus_active;
      adc_reset    <= bus_active && !bus_active_q;
      adc_start    <= !abort && (state_q == MSLI_ST_START);
      if (state_q == MSLI_ST_START)
      begin
        adc_chan    <= cur_ch_q;
        adc_ref_ext <= (cur_ch_q >= MSLI_CH_AIN1) && ctl3_q[`MSLI_CTL3_REF_VDD];
      end
      if ((state_q == MSLI_ST_WAIT) && adc_done)
      begin
        sample_q <= adc_data;
      end
    end
  end

  // ***************************************************
  // results and limits
  // ***************************************************
  msli_limit_cmp u_cmp (
    .value     (store_val),
    .lim_hi    (lim_hi_q[cur_ch_q]),
    .lim_lo    (lim_lo_q[cur_ch_q]),
    .is_signed (ch_temp),
    .above     (above),
    .below     (below)
  );

  assign out_lim = store_fire && (above || below);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 7; i++)
      begin
        val_q[i] <= 10'h000;
      end
    end
    else if (store_fire)
    begin
      val_q[cur_ch_q] <= store_val;
    end
  end

  // ***************************************************
  // flags and interrupt
  // ***************************************************
  always_comb
  begin
    set1 = 6'h00;
    set2 = 1'b0;
    if (out_lim && (cur_ch_q == MSLI_CH_SUPPLY))
    begin
      set2 = !mask2_q[0];
    end
    else if (out_lim)
    begin
      set1[3'(cur_ch_q - 3'h1)] = !mask1_q[3'(cur_ch_q - 3'h1)];
    end
  end

  assign rd_stat1 = reg_rd && (reg_addr == `MSLI_ADDR_STAT1);
  assign rd_stat2 = reg_rd && (reg_addr == `MSLI_ADDR_STAT2);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      stat1_q <= 6'h00;
      stat2_q <= 1'b0;
    end
    else
    begin
      // new event beats the read clear
      stat1_q <= (stat1_q & ~{6{rd_stat1}}) | set1;
      stat2_q <= (stat2_q & !rd_stat2) | set2;
    end
  end

  assign any_irq = (|(stat1_q & ~mask1_q[5:0])) || (stat2_q && !mask2_q[0]);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_out <= 1'b1;
    end
    else
    begin
      irq_out <= cfg1_q[`MSLI_CFG1_IRQ_POL] ? any_irq : !any_irq;
    end
  end

  // ***************************************************
  // register file
  // ***************************************************
  assign lim_off = reg_addr - `MSLI_ADDR_LIM_BASE;
  assign val_off = reg_addr - `MSLI_ADDR_VAL_BASE;

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg1_q  <= `MSLI_CFG1_RST;
      ctl2_q  <= `MSLI_CTL2_RST;
      ctl3_q  <= `MSLI_CTL3_RST;
      mask1_q <= `MSLI_MASK_RST;
      mask2_q <= `MSLI_MASK_RST;
      for (int i = 0; i < 7; i++)
      begin
        lim_hi_q[i] <= ((i == 1) || (i == 2)) ? `MSLI_LIM_HI_T_RST : `MSLI_LIM_HI_V_RST;
        lim_lo_q[i] <= ((i == 1) || (i == 2)) ? `MSLI_LIM_LO_T_RST : `MSLI_LIM_LO_V_RST;
      end
    end
    else if (reg_wr)
    begin
      if (reg_addr == `MSLI_ADDR_CFG1)
      begin
        cfg1_q <= reg_wdata;
      end
      else if (reg_addr == `MSLI_ADDR_CTL2)
      begin
        ctl2_q <= reg_wdata;
      end
      else if (reg_addr == `MSLI_ADDR_CTL3)
      begin
        ctl3_q <= reg_wdata;
      end
      else if (reg_addr == `MSLI_ADDR_MASK1)
      begin
        mask1_q <= reg_wdata;
      end
      else if (reg_addr == `MSLI_ADDR_MASK2)
      begin
        mask2_q <= reg_wdata;
      end
      else if ((reg_addr >= `MSLI_ADDR_LIM_BASE) && (reg_addr <= `MSLI_ADDR_LIM_LAST))
      begin
        if (lim_off[0])
        begin
          lim_lo_q[lim_off[3:1]] <= reg_wdata;
        end
        else
        begin
          lim_hi_q[lim_off[3:1]] <= reg_wdata;
        end
      end
    end
  end

  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_addr == `MSLI_ADDR_STAT1)
    begin
      rdata_d = {2'h0, stat1_q};
    end
    else if (reg_addr == `MSLI_ADDR_STAT2)
    begin
      rdata_d = {7'h00, stat2_q};
    end
    else if (reg_addr == `MSLI_ADDR_LOWB_A)
    begin
      rdata_d = {2'h0, val_q[2][1:0], val_q[1][1:0], val_q[0][1:0]};
    end
    else if (reg_addr == `MSLI_ADDR_LOWB_B)
    begin
      rdata_d = {val_q[6][1:0], val_q[5][1:0], val_q[4][1:0], val_q[3][1:0]};
    end
    else if ((reg_addr >= `MSLI_ADDR_VAL_BASE) && (reg_addr <= `MSLI_ADDR_VAL_LAST))
    begin
      rdata_d = val_q[val_off[2:0]][9:2];
    end
    else if (reg_addr == `MSLI_ADDR_CFG1)
    begin
      rdata_d = cfg1_q;
    end
    else if (reg_addr == `MSLI_ADDR_CTL2)
    begin
      rdata_d = ctl2_q;
    end
    else if (reg_addr == `MSLI_ADDR_CTL3)
    begin
      rdata_d = ctl3_q;
    end
    else if (reg_addr == `MSLI_ADDR_MASK1)
    begin
      rdata_d = mask1_q;
    end
    else if (reg_addr == `MSLI_ADDR_MASK2)
    begin
      rdata_d = mask2_q;
    end
    else if ((reg_addr >= `MSLI_ADDR_LIM_BASE) && (reg_addr <= `MSLI_ADDR_LIM_LAST))
    begin
      rdata_d = lim_off[0] ? lim_lo_q[lim_off[3:1]] : lim_hi_q[lim_off[3:1]];
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_d;
    end
  end

  // ***************************************************
  // checks
  // ***************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  a_abort_reset: assert property ($rose(bus_active) |=> adc_reset)
    else $error("converter not reset at transaction start");
  a_no_start_busy: assert property (bus_active |=> !adc_start)
    else $error("conversion started during transaction");
  a_restart_after: assert property (($fell(bus_active) && cfg1_q[0]) ##1 (!bus_active && cfg1_q[0])
    |-> ##1 adc_start)
    else $error("no restart after transaction");
  a_single_chan: assert property (store_fire && ctl2_q[4] |=> cur_ch_q == single_chan($past(ctl2_q[2:0])))
    else $error("single mode picked wrong channel");
  a_rr_order: assert property (store_fire && !ctl2_q[4]
    |=> cur_ch_q == rr_next($past(cur_ch_q), $past(cfg1_q[1])))
    else $error("round robin order broken");
  a_flag_sticky: assert property (!rd_stat1 |=> (stat1_q & $past(stat1_q)) == $past(stat1_q))
    else $error("flag dropped without read");
  a_limit_flag: assert property (out_lim && (cur_ch_q != MSLI_CH_SUPPLY) && !mask1_q[cur_ch_q - 3'h1]
    |=> stat1_q[$past(cur_ch_q) - 3'h1])
    else $error("limit excursion not flagged");
  a_supply_flag: assert property (out_lim && (cur_ch_q == MSLI_CH_SUPPLY) && !mask2_q[0] |=> stat2_q)
    else $error("supply excursion not flagged");
  a_irq_idle: assert property (!$past(any_irq) && $stable(cfg1_q) |-> irq_out == !cfg1_q[3])
    else $error("interrupt pin active with no flag");
  a_supply_split: assert property (reg_rd && (reg_addr == 8'h06) |=> reg_rdata == $past(val_q[0][9:2]))
    else $error("supply high byte wrong");
  a_supply_ref: assert property (adc_start && (adc_chan < 3'h3) |-> !adc_ref_ext)
    else $error("internal reference not used");

  c_single_run: cover property (adc_start && ctl2_q[4]);
  c_rr_wrap: cover property (store_fire && (cur_ch_q == MSLI_CH_AIN4) && !ctl2_q[4]);
  c_irq_fire: cover property ($rose(any_irq));
  c_abort: cover property ((state_q == MSLI_ST_WAIT) ##1 $rose(bus_active));
endmodule
`default_nettype wire

// ==== verilog/msli_defines.svh ====
// constants for the monitor sequencer and limit checker
// How it works
// - analog code step is reference over 1024
// - upper test greater-than, lower test less-equal
// - 8-bit limits meet 10-bit results
// - unmasked analog excursion sets status one flag
// - pending unmasked flag drives pin, polarity selectable
// - temperatures checked against own high low limits
// - single mode repeats selected channel back to back
// - round robin fixed channel order, results stored
// - temperature span -128..127, quarter degree steps
// - averaging stores mean of sixteen conversions
// - slow conversion times, internal and external temperature
// - temperature result held in two byte registers
// - bit five disables averaging, enabled at power-up
// - round robin converts both temperatures every pass unless pins are analog inputs, then internal only
// - new measurement after each host transaction
// - transaction aborts conversion, resets converter, restarts after
// - supply result split, low bits 03h, high 06h
// - unmasked supply excursion sets status two flag
// - supply and temperatures always use internal reference
// - temperatures are 10-bit two's complement
// - monitoring disabled at power-up until enable bit
// - single enable bit switches single and round robin
`ifndef MSLI_DEFINES_SVH
`define MSLI_DEFINES_SVH
`define MSLI_ADDR_STAT1      8'h00
`define MSLI_ADDR_STAT2      8'h01
`define MSLI_ADDR_LOWB_A     8'h03
`define MSLI_ADDR_LOWB_B     8'h04
`define MSLI_ADDR_VAL_BASE   8'h06
`define MSLI_ADDR_VAL_LAST   8'h0c
`define MSLI_ADDR_CFG1       8'h18
`define MSLI_ADDR_CTL2       8'h19
`define MSLI_ADDR_CTL3       8'h1a
`define MSLI_ADDR_MASK1      8'h1d
`define MSLI_ADDR_MASK2      8'h1e
`define MSLI_ADDR_LIM_BASE   8'h20
`define MSLI_ADDR_LIM_LAST   8'h2d
`define MSLI_CFG1_EN         0
`define MSLI_CFG1_PINS_AIN   1
`define MSLI_CFG1_IRQ_POL    3
`define MSLI_CTL2_SINGLE     4
`define MSLI_CTL2_AVG_OFF    5
`define MSLI_CTL3_REF_VDD    4
`define MSLI_CFG1_RST        8'h00
`define MSLI_CTL2_RST        8'h00
`define MSLI_CTL3_RST        8'h00
`define MSLI_MASK_RST        8'h00
`define MSLI_LIM_HI_V_RST    8'hff
`define MSLI_LIM_LO_V_RST    8'h00
`define MSLI_LIM_HI_T_RST    8'h7f
`define MSLI_LIM_LO_T_RST    8'h80
`define MSLI_ADC_CODES       1024
`define MSLI_AVG_LAST        4'hf
`define MSLI_AVG_SHIFT       4
`define MSLI_CLK_MHZ         25
`define MSLI_INT_CONV_NS     712000
`define MSLI_EXT_CONV_NS     1510000
`define MSLI_CONV_TIMEOUT_CYC ((2 * `MSLI_EXT_CONV_NS * `MSLI_CLK_MHZ) / 1000)
`endif

// ==== verilog/msli_pkg.sv ====
// types and channel helpers of the monitor sequencer
`default_nettype none
package msli_pkg;
  typedef enum logic [2:0] {
    MSLI_CH_SUPPLY = 3'h0,
    MSLI_CH_INT    = 3'h1,
    MSLI_CH_EXT    = 3'h2,
    MSLI_CH_AIN1   = 3'h3,
    MSLI_CH_AIN2   = 3'h4,
    MSLI_CH_AIN3   = 3'h5,
    MSLI_CH_AIN4   = 3'h6
  } msli_chan_t;

  typedef enum logic [3:0] {
    MSLI_ST_IDLE  = 4'h1,
    MSLI_ST_START = 4'h2,
    MSLI_ST_WAIT  = 4'h4,
    MSLI_ST_STORE = 4'h8
  } msli_state_t;

  function automatic logic chan_is_temp(input msli_chan_t ch);
    return (ch == MSLI_CH_INT) || (ch == MSLI_CH_EXT);
  endfunction

  function automatic msli_chan_t single_chan(input logic [2:0] sel);
    if (sel == 3'h7)
    begin
      return MSLI_CH_SUPPLY;
    end
    return msli_chan_t'(sel);
  endfunction

  function automatic msli_chan_t rr_next(input msli_chan_t ch, input logic pins_ain);
    case (ch)
      MSLI_CH_SUPPLY: return MSLI_CH_INT;
      MSLI_CH_INT:    return pins_ain ? MSLI_CH_AIN1 : MSLI_CH_EXT;
      MSLI_CH_EXT:    return MSLI_CH_AIN3;
      MSLI_CH_AIN1:   return MSLI_CH_AIN2;
      MSLI_CH_AIN2:   return MSLI_CH_AIN3;
      MSLI_CH_AIN3:   return MSLI_CH_AIN4;
      default:        return MSLI_CH_SUPPLY;
    endcase
  endfunction
endpackage
`default_nettype wire

// ==== verilog/msli_limit_cmp.sv ====
// window comparator of one result against its byte limits
`timescale 1ns/10ps
`default_nettype none
module msli_limit_cmp
  import msli_pkg::*;
(
  // result and limits
  input  wire logic [9:0] value,
  input  wire logic [7:0] lim_hi,
  input  wire logic [7:0] lim_lo,
  input  wire logic       is_signed,
  // outcome
  output logic            above,
  output logic            below
);
  logic [7:0] top8;

  // only the upper byte meets the limit
  assign top8 = value[9:2];

  always_comb
  begin
    if (is_signed)
    begin
      above = $signed(top8) > $signed(lim_hi);
      below = $signed(top8) <= $signed(lim_lo);
    end
    else
    begin
      above = top8 > lim_hi;
      below = top8 <= lim_lo;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/msli_averager.sv ====
// sixteen-sample temperature averager with pass-through
`timescale 1ns/10ps
`default_nettype none
`include "msli_defines.svh"
module msli_averager
  import msli_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  // control
  input  wire logic       clear,
  input  wire logic       avg_on,
  // samples in
  input  wire logic       sample_valid,
  input  wire logic [9:0] sample,
  // result out
  output logic            result_valid,
  output logic [9:0]      result
);
  logic [13:0] acc_q;
  logic [3:0]  cnt_q;
  logic [13:0] sum;

  assign sum = acc_q + {{4{sample[9]}}, sample};

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_q <= 14'h0000;
      cnt_q <= 4'h0;
    end
    else if (clear || !avg_on)
    begin
      acc_q <= 14'h0000;
      cnt_q <= 4'h0;
    end
    else if (sample_valid)
    begin
      if (cnt_q == `MSLI_AVG_LAST)
      begin
        acc_q <= 14'h0000;
        cnt_q <= 4'h0;
      end
      else
      begin
        acc_q <= sum;
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      result_valid <= 1'b0;
      result       <= 10'h000;
    end
    else
    begin
      result_valid <= !clear && sample_valid && (!avg_on || (cnt_q == `MSLI_AVG_LAST));
      // arithmetic mean keeps the two's complement form
      result       <= avg_on ? sum[13:`MSLI_AVG_SHIFT] : sample;
    end
  end
endmodule
`default_nettype wire

// ==== bench/msli_adc_model.sv ====
// behavioural converter answering the sequencer's start pulses
`timescale 1ns/10ps
`default_nettype none
module msli_adc_model
#(
  parameter int LAT = 6
)
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // converter control
  input  wire logic        adc_start,
  input  wire logic        adc_reset,
  input  wire logic [2:0]  adc_chan,
  input  wire logic [69:0] codes,
  // result
  output logic             adc_done,
  output logic [9:0]       adc_data
);
  int         cnt_q;
  logic       alt_q;
  logic [9:0] last_q;
  logic [9:0] code;

  // temperatures alternate by eight codes so averaging shows
  assign code = codes[adc_chan * 10 +: 10]
              + ((alt_q && (adc_chan inside {3'h1, 3'h2})) ? 10'h008 : 10'h000);

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_q    <= 0;
      adc_done <= 1'b0;
      alt_q    <= 1'b0;
      last_q   <= 10'h000;
    end
    else
    begin
      adc_done <= 1'b0;
      if (adc_reset)
        cnt_q <= 0;
      else if (adc_start)
        cnt_q <= LAT;
      else if (cnt_q == 1)
      begin
        cnt_q    <= 0;
        adc_done <= 1'b1;
        last_q   <= code;
        alt_q    <= !alt_q;
      end
      else if (cnt_q > 1)
        cnt_q <= cnt_q - 1;
    end
  end

  // idle data lines show the inverse of the last result
  assign adc_data = adc_done ? last_q : ~last_q;
endmodule
`default_nettype wire

// ==== bench/msli_monitor_top_bench.sv ====
// self-checking bench of the monitor sequencer top
`timescale 1ns/10ps
`default_nettype none
module msli_monitor_top_bench;
  logic        clk_sys;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        bus_active;
  logic        adc_start;
  logic        adc_reset;
  logic [2:0]  adc_chan;
  logic        adc_ref_ext;
  logic        adc_done;
  logic [9:0]  adc_data;
  logic        irq_out;
  logic [69:0] codes;
  logic [2:0]  chan_log [0:4095];
  int          n_start;
  int          n_checks;
  int          n_mismatch;
  int          cyc;

  msli_monitor_top #(.CONV_TIMEOUT_CYC(50)) uut (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_active(bus_active), .adc_start(adc_start),
    .adc_reset(adc_reset), .adc_chan(adc_chan), .adc_ref_ext(adc_ref_ext),
    .adc_done(adc_done), .adc_data(adc_data), .irq_out(irq_out));

  msli_adc_model #(.LAT(6)) adc (.clk_sys(clk_sys), .resetn(resetn), .adc_start(adc_start),
    .adc_reset(adc_reset), .adc_chan(adc_chan), .codes(codes), .adc_done(adc_done),
    .adc_data(adc_data));

  always #20 clk_sys = ~clk_sys;

  // start log and hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (adc_start === 1'b1)
    begin
      chan_log[n_start] <= adc_chan;
      n_start <= n_start + 1;
    end
    if (cyc == 30000)
    begin
      n_mismatch++;
      summarize;
    end
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t flag %b exp %b", $time, got, exp);
    end
  endtask

  // one host transaction of a single byte access
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk_sys) #1 bus_active = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk_sys) #1 reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(posedge clk_sys) #1 q = reg_rdata;
    bus_active = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    acc(1'b0, a, 8'h00, q);
    chk8(q, exp);
  endtask

  task automatic wait_starts(input int n);
    int k;
    k = n_start + n;
    for (int i = 0; i < 3000 && n_start < k; i++) @(posedge clk_sys);
    #1 chk1(n_start >= k, 1'b1);
  endtask

  task automatic t_reset;
    wr(8'h06, 8'h55);
    rd_chk(8'h06, 8'h00);
    rd_chk(8'h19, 8'h00);
    rd_chk(8'h18, 8'h00);
    rd_chk(8'h20, 8'hff);
    rd_chk(8'h3f, 8'h00);
    chk1(n_start == 0, 1'b1);
    chk1(irq_out, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_robin;
    int b;
    logic [2:0] ord [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6, 3'h0};
    wr(8'h19, 8'h20);
    wr(8'h18, 8'h01);
    b = n_start;
    wait_starts(6);
    for (int i = 0; i < 6; i++) chk8({5'h0, chan_log[b + i]}, {5'h0, ord[i]});
    rd_chk(8'h06, 8'hc9);
    rd_chk(8'h03, 8'h01);
    $display("test robin done");
  endtask

  task automatic t_limits;
    wr(8'h20, 8'hc0);
    wr(8'h22, 8'hfe);
    wr(8'h2b, 8'h40);
    wr(8'h2c, 8'h50);
    wr(8'h25, 8'h20);
    wr(8'h1d, 8'h02);
    wait_starts(7);
    chk1(irq_out, 1'b0);
    wr(8'h20, 8'hff);
    wr(8'h22, 8'h7f);
    wr(8'h2b, 8'h00);
    wait_starts(7);
    rd_chk(8'h00, 8'h11);
    rd_chk(8'h01, 8'h01);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h01, 8'h00);
    @(posedge clk_sys) #1 chk1(irq_out, 1'b1);
    wr(8'h18, 8'h09);
    wr(8'h20, 8'hc0);
    wait_starts(7);
    chk1(irq_out, 1'b1);
    wr(8'h20, 8'hff);
    $display("test limits done");
  endtask

  task automatic t_abort;
    logic seen;
    int b;
    int c;
    wait_starts(1);
    @(posedge clk_sys) #1 bus_active = 1'b1;
    seen = 1'b0;
    repeat (3) @(posedge clk_sys) #1 seen = seen | adc_reset;
    chk1(seen, 1'b1);
    b = n_start;
    repeat (10) @(posedge clk_sys);
    #1 chk1(n_start == b, 1'b1);
    bus_active = 1'b0;
    c = 0;
    while (adc_start !== 1'b1 && c < 10) @(posedge clk_sys) #1 c++;
    chk1(c >= 1 && c <= 3, 1'b1);
    $display("test abort done");
  endtask

  task automatic t_single;
    int b;
    logic ok;
    logic [7:0] q;
    codes[19:10] = 10'h100;
    wr(8'h19, 8'h11);
    b = n_start;
    wait_starts(18);
    ok = 1'b1;
    for (int i = b; i < b + 18; i++) ok = ok & (chan_log[i] === 3'h1);
    chk1(ok, 1'b1);
    rd_chk(8'h07, 8'h41);
    wr(8'h19, 8'h31);
    wait_starts(3);
    acc(1'b0, 8'h07, 8'h00, q);
    chk1(q === 8'h40 || q === 8'h42, 1'b1);
    wr(8'h19, 8'h10);
    wait_starts(3);
    chk8({5'h0, chan_log[n_start - 1]}, 8'h00);
    $display("test single done");
  endtask

  // pins as analog inputs, supply reference and select code seven
  task automatic t_pins;
    int b;
    logic [2:0] ord [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};
    codes[39:30] = 10'h2a8;
    wr(8'h19, 8'h20);
    wr(8'h1a, 8'h10);
    wr(8'h18, 8'h0b);
    b = n_start;
    wait_starts(7);
    for (int i = 0; i < 7; i++) chk8({5'h0, chan_log[b + i]}, {5'h0, ord[i]});
    rd_chk(8'h09, 8'haa);
    wr(8'h19, 8'h35);
    wait_starts(2);
    chk1(adc_ref_ext, 1'b1);
    wr(8'h19, 8'h37);
    wait_starts(2);
    chk1(adc_ref_ext, 1'b0);
    chk8({5'h0, chan_log[n_start - 1]}, 8'h00);
    $display("test pins done");
  endtask

  initial
  begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    bus_active = 1'b0;
    n_start = 0;
    n_checks = 0;
    n_mismatch = 0;
    cyc = 0;
    codes = {10'h140, 10'h100, 10'h000, 10'h000, 10'h050, 10'h3fc, 10'h325};
    repeat (12) @(posedge clk_sys);
    #1 resetn = 1'b1;
    t_reset;
    t_robin;
    t_limits;
    t_abort;
    t_single;
    t_pins;
    summarize;
  end
endmodule
`default_nettype wire
